// [design/pilot_pkg.sv]
/*
 pilot_pkg: shared constants and carrier types for the pilot signal controller.
 assumes a 20 MHz system clock and an 8-bit pilot high-level sample code.
*/
package pilot_pkg;
	// clock and pilot period
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned PILOT_HZ      = 1_000;
	localparam int unsigned PERIOD_CYC    = CLK_HZ / PILOT_HZ;
	localparam int unsigned CNT_W         = 15;
	// self-test time after reset, in microseconds
	localparam int unsigned SELFTEST_US   = 100;
	localparam int unsigned SELFTEST_CYC  = (SELFTEST_US * (CLK_HZ / 1_000_000));
	// advertised current limits in amperes
	localparam logic [6:0]  AMP_MIN       = 7'h06;
	localparam logic [6:0]  AMP_KNEE      = 7'h33;
	localparam logic [6:0]  AMP_MAX       = 7'h50;
	// duty scaled to tenths of a percent: low band amps*100/6, high band amps*4+640
	localparam int unsigned DUTY_LO_NUM   = 100;
	localparam int unsigned DUTY_LO_DEN   = 6;
	localparam int unsigned DUTY_HI_MUL   = 4;
	localparam int unsigned DUTY_HI_OFS   = 640;
	localparam int unsigned DUTY_FULL     = 1000;
	// pilot high-level windows on the sample code (12 V full scale = 8'hf0)
	localparam logic [7:0]  LVL_12_MIN    = 8'hd2;
	localparam logic [7:0]  LVL_9_MIN     = 8'h96;
	localparam logic [7:0]  LVL_9_MAX     = 8'hc8;
	localparam logic [7:0]  LVL_6_MIN     = 8'h5a;
	localparam logic [7:0]  LVL_6_MAX     = 8'h8c;
	localparam logic [7:0]  LVL_3_MIN     = 8'h1e;
	localparam logic [7:0]  LVL_3_MAX     = 8'h50;
	localparam logic [7:0]  LVL_0_MAX     = 8'h14;
	// sampling point inside the high phase and agreement count
	localparam int unsigned SAMPLE_DLY    = 400;
	localparam int unsigned AGREE_CNT     = 4;

	// classified pilot level
	typedef enum logic [2:0] {
		LVL_12V, LVL_9V, LVL_6V, LVL_3V, LVL_0V, LVL_NEG, LVL_BAD
	} level_t;

	// connection state
	typedef enum logic [2:0] {
		ST_SELFTEST, ST_IDLE, ST_READY, ST_CHARGE, ST_VENT, ST_ERROR, ST_FAULT
	} conn_t;

	// pilot drive carrier
	typedef struct packed {
		logic pos;      // drive +12 V
		logic neg;      // drive -12 V
	} drive_t;

	// station status carrier
	typedef struct packed {
		conn_t  state;
		logic   relay_on;
		logic   fault;
	} status_t;
endpackage

// [design/duty_calc.sv]
/*
 duty_calc: converts an advertised current in amperes into a high time in clock cycles.
 assumes the amps input is stable for one cycle; result is registered.
*/
`timescale 1ns/1ps
module duty_calc #(
	parameter int unsigned PERIOD = pilot_pkg::PERIOD_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// current in, duty out
	input  wire logic [6:0]  amps,
	output logic      [14:0] high_cyc,
	output logic             valid
);
	logic [31:0] tenths;
	logic [31:0] cyc;
	logic [14:0] high_cyc_nxt;
	logic        valid_nxt;

	// piecewise duty law, then scale to the period
	always_comb begin
		tenths = 32'h0000_0000;
		valid_nxt = 1'b0;
		if (amps >= pilot_pkg::AMP_MIN && amps <= pilot_pkg::AMP_KNEE) begin
			tenths = (32'(amps) * pilot_pkg::DUTY_LO_NUM) / pilot_pkg::DUTY_LO_DEN;
			valid_nxt = 1'b1;
		end else if (amps > pilot_pkg::AMP_KNEE && amps <= pilot_pkg::AMP_MAX) begin
			tenths = 32'(amps) * pilot_pkg::DUTY_HI_MUL + pilot_pkg::DUTY_HI_OFS;
			valid_nxt = 1'b1;
		end
		cyc = (tenths * PERIOD) / pilot_pkg::DUTY_FULL;
		high_cyc_nxt = cyc[14:0];
	end

	// result register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			high_cyc <= 15'h0000;
			valid    <= 1'b0;
		end else begin
			high_cyc <= high_cyc_nxt;
			valid    <= valid_nxt;
		end
	end
endmodule

// [design/level_filter.sv]
/*
 level_filter: classifies pilot high-level samples and accepts a level after repeated agreement.
 assumes sample_en pulses once per pilot period during the high phase.
*/
`timescale 1ns/1ps
module level_filter #(
	parameter int unsigned AGREE = pilot_pkg::AGREE_CNT
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// sample in
	input  wire logic             sample_en,
	input  wire logic [7:0]       high_code,
	input  wire logic             low_neg,
	// accepted level
	output pilot_pkg::level_t     level
);
	pilot_pkg::level_t raw;
	pilot_pkg::level_t cand_r, cand_nxt;
	pilot_pkg::level_t level_nxt;
	logic [3:0]        cnt_r, cnt_nxt;

	// tolerance windows around each nominal level
	always_comb begin
		if (high_code >= pilot_pkg::LVL_12_MIN)
			raw = pilot_pkg::LVL_12V;
		else if (high_code >= pilot_pkg::LVL_9_MIN && high_code <= pilot_pkg::LVL_9_MAX)
			raw = pilot_pkg::LVL_9V;
		else if (high_code >= pilot_pkg::LVL_6_MIN && high_code <= pilot_pkg::LVL_6_MAX)
			raw = pilot_pkg::LVL_6V;
		else if (high_code >= pilot_pkg::LVL_3_MIN && high_code <= pilot_pkg::LVL_3_MAX)
			raw = pilot_pkg::LVL_3V;
		else if (high_code <= pilot_pkg::LVL_0_MAX)
			raw = low_neg ? pilot_pkg::LVL_NEG : pilot_pkg::LVL_0V;
		else
			raw = pilot_pkg::LVL_BAD;
	end

	// debounce: accept after AGREE matching samples
	always_comb begin
		cand_nxt  = cand_r;
		cnt_nxt   = cnt_r;
		level_nxt = level;
		if (sample_en) begin
			if (raw != cand_r) begin
				cand_nxt = raw;
				cnt_nxt  = 4'h1;
			end else if (cnt_r < 4'(AGREE)) begin
				cnt_nxt = cnt_r + 4'h1;
			end
			if (raw == cand_r && cnt_r + 4'h1 >= 4'(AGREE))
				level_nxt = raw;
		end
	end

	// filter state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cand_r <= pilot_pkg::LVL_12V;
			cnt_r  <= 4'h0;
			level  <= pilot_pkg::LVL_12V;
		end else begin
			cand_r <= cand_nxt;
			cnt_r  <= cnt_nxt;
			level  <= level_nxt;
		end
	end
endmodule

// [design/ev_pilot_signal_controller.sv]
/*
 ev_pilot_signal_controller: station side of the ev control pilot link.
 generates the 1 kHz pilot drive, classifies the sampled level and sequences the relays.
 assumes an external amplifier maps drive to +/-12 V and an adc supplies the divided
 pilot level as an 8-bit code every cycle, synchronous to clk.
*/
// What this block does
// - drive a 1 kHz plus/minus 12 V square wave when advertising current.
// - duty cycle advertises the maximum current the station can supply.
// - from 6 to 51 A, duty percent equals amps divided by 0.6.
// - above 51 up to 80 A, duty equals amps over 2.5 plus 64.
// - 15 A gives 25%, 30 A gives 50%, 80 A gives 96%.
// - not connected: steady +12 V with no modulation.
// - 9 V ready, 6 V charging, 3 V ventilation, 0 V error, negative-only fault.
// - ventilation charging keeps 1 kHz modulation with -12 V low level.
// - finish self-test after power-on, then enter not-connected with steady +12 V.
// - on ready level, enter ready, start modulation and close the power relays.
// - return to 12 V means unplug: open relays, back to not-connected.
// - on fault such as missing diode, cut power to the vehicle.
// - advertised current normally is a fixed configuration value.
// - current may be derated; duty then updates to match.
// - sample the divided pilot driver output to infer vehicle load.
`timescale 1ns/1ps
module ev_pilot_signal_controller #(
	parameter logic [6:0]  RATED_AMPS   = 7'h20,
	parameter int unsigned PERIOD       = pilot_pkg::PERIOD_CYC,
	parameter int unsigned SELFTEST     = pilot_pkg::SELFTEST_CYC,
	parameter int unsigned SAMPLE_AT    = pilot_pkg::SAMPLE_DLY
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// configuration
	input  wire logic               derate_en,
	input  wire logic [6:0]         derate_amps,
	input  wire logic               selftest_ok,
	// pilot sense
	input  wire logic [7:0]         pilot_code,
	input  wire logic               pilot_low_neg,
	// pilot drive and power control
	output pilot_pkg::drive_t       drive,
	output logic                    relay_en,
	output pilot_pkg::status_t      status
);
	// state
	pilot_pkg::conn_t    st_r, st_nxt;
	logic [14:0]         cnt_r, cnt_nxt;
	logic [14:0]         high_r, high_nxt;
	logic                mod_ok_r, mod_ok_nxt;
	logic [14:0]         st_tmr_r, st_tmr_nxt;
	logic                sample_en_r, sample_en_nxt;
	logic [7:0]          code_r, code_nxt;
	logic                neg_r, neg_nxt;
	pilot_pkg::drive_t   drive_nxt;
	logic                relay_nxt;
	pilot_pkg::status_t  status_nxt;
	logic [6:0]          amps;
	logic [14:0]         calc_high;
	logic                calc_valid;
	logic                modulate;
	logic                bound;
	pilot_pkg::level_t   level;

	// advertised current: fixed rating unless derated lower
	always_comb begin
		amps = RATED_AMPS;
		if (derate_en && derate_amps < RATED_AMPS)
			amps = derate_amps;
	end

	duty_calc #(
		.PERIOD    (PERIOD)
	) u_duty (
		.clk       (clk),
		.rst_n     (rst_n),
		.amps      (amps),
		.high_cyc  (calc_high),
		.valid     (calc_valid)
	);

	level_filter #(
		.AGREE     (pilot_pkg::AGREE_CNT)
	) u_level (
		.clk       (clk),
		.rst_n     (rst_n),
		.sample_en (sample_en_r),
		.high_code (code_r),
		.low_neg   (neg_r),
		.level     (level)
	);

	// modulation is active in the ready, charging and ventilation states
	always_comb begin
		modulate = (st_r == pilot_pkg::ST_READY) ||
		           (st_r == pilot_pkg::ST_CHARGE) ||
		           (st_r == pilot_pkg::ST_VENT);
		bound = (cnt_r == 15'(PERIOD - 1));
	end

	// period counter with duty latched only at the period boundary
	always_comb begin
		cnt_nxt    = bound ? 15'h0000 : cnt_r + 15'h0001;
		high_nxt   = high_r;
		mod_ok_nxt = mod_ok_r;
		if (bound) begin
			high_nxt   = calc_high;
			mod_ok_nxt = calc_valid;
		end
	end

	// capture the divided pilot level inside the high phase
	always_comb begin
		sample_en_nxt = 1'b0;
		code_nxt      = code_r;
		neg_nxt       = neg_r;
		if (cnt_r == 15'(SAMPLE_AT)) begin
			code_nxt      = pilot_code;
			sample_en_nxt = 1'b1;
		end
		if (cnt_r == 15'(PERIOD - 2))
			neg_nxt = pilot_low_neg;
	end

	// connection state sequencing
	always_comb begin
		st_nxt     = st_r;
		st_tmr_nxt = st_tmr_r;
		case (st_r)
			pilot_pkg::ST_SELFTEST: begin
				if (st_tmr_r != 15'(SELFTEST))
					st_tmr_nxt = st_tmr_r + 15'h0001;
				else if (selftest_ok)
					st_nxt = pilot_pkg::ST_IDLE;
			end
			pilot_pkg::ST_IDLE: begin
				if (level == pilot_pkg::LVL_9V && mod_ok_r)
					st_nxt = pilot_pkg::ST_READY;
				else if (level == pilot_pkg::LVL_0V || level == pilot_pkg::LVL_NEG)
					st_nxt = pilot_pkg::ST_FAULT;
			end
			pilot_pkg::ST_READY, pilot_pkg::ST_CHARGE, pilot_pkg::ST_VENT: begin
				case (level)
					pilot_pkg::LVL_12V: st_nxt = pilot_pkg::ST_IDLE;
					pilot_pkg::LVL_9V:  st_nxt = pilot_pkg::ST_READY;
					pilot_pkg::LVL_6V:  st_nxt = pilot_pkg::ST_CHARGE;
					pilot_pkg::LVL_3V:  st_nxt = pilot_pkg::ST_VENT;
					pilot_pkg::LVL_0V:  st_nxt = pilot_pkg::ST_ERROR;
					default:            st_nxt = pilot_pkg::ST_FAULT;
				endcase
				if (!mod_ok_r)
					st_nxt = pilot_pkg::ST_IDLE;
			end
			pilot_pkg::ST_ERROR, pilot_pkg::ST_FAULT: begin
				if (level == pilot_pkg::LVL_12V)
					st_nxt = pilot_pkg::ST_IDLE;
			end
			default: st_nxt = pilot_pkg::ST_SELFTEST;
		endcase
	end

	// pilot drive, relay and status outputs
	always_comb begin
		drive_nxt.pos = 1'b0;
		drive_nxt.neg = 1'b0;
		relay_nxt     = 1'b0;
		if (st_r == pilot_pkg::ST_IDLE) begin
			drive_nxt.pos = 1'b1;
		end else if (modulate && mod_ok_r) begin
			drive_nxt.pos = (cnt_nxt < high_nxt);
			drive_nxt.neg = !(cnt_nxt < high_nxt);
			relay_nxt     = 1'b1;
		end else if (st_r == pilot_pkg::ST_FAULT || st_r == pilot_pkg::ST_ERROR) begin
			drive_nxt.neg = 1'b1;
		end
		status_nxt.state    = st_r;
		status_nxt.relay_on = relay_nxt;
		status_nxt.fault    = (st_r == pilot_pkg::ST_FAULT) || (st_r == pilot_pkg::ST_ERROR);
	end

	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r        <= pilot_pkg::ST_SELFTEST;
			st_tmr_r    <= 15'h0000;
			cnt_r       <= 15'h0000;
			high_r      <= 15'h0000;
			mod_ok_r    <= 1'b0;
			sample_en_r <= 1'b0;
			code_r      <= 8'h00;
			neg_r       <= 1'b0;
			drive       <= '0;
			relay_en    <= 1'b0;
			status      <= '0;
		end else begin
			st_r        <= st_nxt;
			st_tmr_r    <= st_tmr_nxt;
			cnt_r       <= cnt_nxt;
			high_r      <= high_nxt;
			mod_ok_r    <= mod_ok_nxt;
			sample_en_r <= sample_en_nxt;
			code_r      <= code_nxt;
			neg_r       <= neg_nxt;
			drive       <= drive_nxt;
			relay_en    <= relay_nxt;
			status      <= status_nxt;
		end
	end
endmodule

// [dv/pilot_asserts.sv]
/*
 pilot_asserts: port checks for the pilot controller.
 assumes a bind to the top module with PERIOD handed on.
*/
`timescale 1ns/1ps
module pilot_asserts #(
	parameter int unsigned PERIOD = pilot_pkg::PERIOD_CYC
) (
	// clock and reset
	input wire logic               clk,
	input wire logic               rst_n,
	// watched ports
	input wire logic               selftest_ok,
	input wire pilot_pkg::drive_t  drive,
	input wire logic               relay_en,
	input wire pilot_pkg::status_t status
);
	localparam int unsigned HI_MAX = PERIOD * 96 / 100;
	logic        pos_r, ok_r, ok_nxt, rise, mod;
	logic [15:0] since_r, since_nxt, hi_r, hi_nxt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// rise of the high phase, cycles since it, high run length
	always_comb begin
		rise      = drive.pos & ~pos_r;
		mod       = status.state inside {pilot_pkg::ST_READY, pilot_pkg::ST_CHARGE,
			pilot_pkg::ST_VENT};
		since_nxt = rise ? 16'h0000 : since_r + 16'h0001;
		ok_nxt    = relay_en & (rise | ok_r); // a rise already seen inside this relay-on run
		hi_nxt    = drive.pos ? hi_r + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_r   <= 1'b0;
			ok_r    <= 1'b0;
			since_r <= 16'h0000;
			hi_r    <= 16'h0000;
		end else begin
			pos_r   <= drive.pos;
			ok_r    <= ok_nxt;
			since_r <= since_nxt;
			hi_r    <= hi_nxt;
		end
	end

	a_drive_excl: assert property (!(drive.pos && drive.neg))
		else $error("both drive polarities on");
	a_period_len: assert property (rise && ok_r |-> since_r == 16'(PERIOD - 1))
		else $error("pilot period length wrong");
	a_high_max: assert property (ok_r |-> hi_r <= 16'(HI_MAX))
		else $error("high phase too long");
	a_idle_steady: assert property (status.state == pilot_pkg::ST_IDLE &&
		$past(status.state) == pilot_pkg::ST_IDLE |-> drive.pos && !drive.neg)
		else $error("idle pilot not steady high");
	a_relay_off: assert property (!mod && !$past(mod) |-> !relay_en)
		else $error("relay on outside charging states");
	a_err_cut: assert property ((status.state inside {pilot_pkg::ST_ERROR,
		pilot_pkg::ST_FAULT})[*2] |-> drive.neg && !drive.pos && !relay_en)
		else $error("error state not cut off");
	a_reset_start: assert property ($rose(rst_n) |->
		status.state == pilot_pkg::ST_SELFTEST && !relay_en && drive == 2'b00)
		else $error("not in self-test after reset");
	a_selftest_hold: assert property ((status.state == pilot_pkg::ST_SELFTEST &&
		!selftest_ok)[*2] |=> status.state == pilot_pkg::ST_SELFTEST)
		else $error("left self-test without pass");
	a_ready_first: assert property ($rose(relay_en) |->
		status.state == pilot_pkg::ST_READY)
		else $error("relay closed outside ready");

	// main scenarios
	c_charge: cover property (status.state == pilot_pkg::ST_CHARGE);
	c_vent: cover property (status.state == pilot_pkg::ST_VENT);
	c_fault: cover property (status.state == pilot_pkg::ST_FAULT);
endmodule

bind ev_pilot_signal_controller pilot_asserts #(.PERIOD(PERIOD)) u_chk (.clk(clk),
	.rst_n(rst_n), .selftest_ok(selftest_ok), .drive(drive), .relay_en(relay_en),
	.status(status));

// [dv/ev_model.sv]
/*
 ev_model: vehicle load on the pilot line, behavioural.
 assumes drive is the station amplifier; mode selects the vehicle load.
*/
`timescale 1ns/1ps
module ev_model (
	// station drive and chosen load
	input  wire pilot_pkg::drive_t drive,
	input  wire pilot_pkg::level_t mode,
	// sensed pilot
	output logic [7:0]             pilot_code,
	output logic                   pilot_low_neg
);
	logic [7:0] hi_code;

	// load sets the high level, diode passes the low phase
	always_comb begin
		case (mode)
			pilot_pkg::LVL_12V: hi_code = 8'hf0;
			pilot_pkg::LVL_9V: hi_code = 8'hb4;
			pilot_pkg::LVL_6V: hi_code = 8'h78;
			pilot_pkg::LVL_3V: hi_code = 8'h3c;
			default: hi_code = 8'h00;
		endcase
		pilot_code    = drive.pos ? hi_code : 8'h00;
		pilot_low_neg = drive.neg && (mode != pilot_pkg::LVL_0V);
	end
endmodule

// [dv/tb_ev_pilot_signal_controller.sv]
/*
 tb_ev_pilot_signal_controller: directed scenarios for the pilot controller.
 assumes shortened period and self-test; vehicle load from ev_model.
*/
`timescale 1ns/1ps
module tb_ev_pilot_signal_controller;
	localparam int PER = 500;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic               derate_en = 1'b0;
	logic [6:0]         derate_amps = 7'h50;
	logic               selftest_ok = 1'b0;
	logic [7:0]         pilot_code;
	logic               pilot_low_neg;
	logic               relay_en;
	pilot_pkg::drive_t  drive;
	pilot_pkg::status_t status;
	pilot_pkg::level_t  mode = pilot_pkg::LVL_12V;
	int                 err_total = 0;
	int                 total_checks = 0;
	int                 hi;
	int                 per;
	int                 amps[7] = '{6, 15, 30, 51, 52, 65, 80};

	always #25 clk = ~clk;

	ev_pilot_signal_controller #(.RATED_AMPS(7'h50), .PERIOD(PER), .SELFTEST(20),
		.SAMPLE_AT(40)) DUT (.clk(clk), .rst_n(rst_n), .derate_en(derate_en),
		.derate_amps(derate_amps), .selftest_ok(selftest_ok), .pilot_code(pilot_code),
		.pilot_low_neg(pilot_low_neg), .drive(drive), .relay_en(relay_en), .status(status));
	ev_model car (.drive(drive), .mode(mode), .pilot_code(pilot_code),
		.pilot_low_neg(pilot_low_neg));

	task automatic final_report;
		if (err_total == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic tmo;
		err_total++;
		final_report();
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// state, relay and the status copies of relay and fault
	task automatic chk_st(input pilot_pkg::conn_t s, input logic rel);
		logic flt;
		flt = (s == pilot_pkg::ST_ERROR) || (s == pilot_pkg::ST_FAULT);
		chk({10'h000, status.state, status.relay_on, status.fault, relay_en},
			{10'h000, s, rel, flt, rel});
	endtask
	task automatic set_mode(input pilot_pkg::level_t m);
		@(posedge clk);
		mode <= m;
	endtask
	// bounded wait for a state, then let outputs follow
	task automatic wait_st(input pilot_pkg::conn_t s, input logic rel);
		int n;
		for (n = 0; n < 8 * PER && status.state !== s; n++)
			@(negedge clk);
		if (n >= 8 * PER) tmo();
		repeat (2) @(negedge clk);
		chk_st(s, rel);
	endtask
	// high length and high plus negative length of one full cycle
	task automatic meas;
		int n;
		for (n = 0; n < 2 * PER && drive.pos !== 1'b0; n++)
			@(negedge clk);
		if (n >= 2 * PER) tmo();
		for (n = 0; n < 2 * PER && drive.pos !== 1'b1; n++)
			@(negedge clk);
		if (n >= 2 * PER) tmo();
		for (n = 0; n < 2 * PER && drive.pos === 1'b1; n++)
			@(negedge clk);
		hi = n;
		for (n = 0; n < 2 * PER && drive.neg === 1'b1; n++)
			@(negedge clk);
		per = hi + n;
	endtask
	function automatic int exp_hi(input int a);
		return (a <= 51 ? a * 100 / 6 : a * 4 + 640) * PER / 1000;
	endfunction
	task automatic t_duty(input int a);
		@(posedge clk);
		derate_amps <= 7'(a);
		derate_en <= 1'b1;
		meas();
		meas();
		chk(16'(hi), 16'(exp_hi(a)));
		chk(16'(per), 16'(PER));
	endtask
	// self-test gate, then steady high level
	task automatic t_start;
		@(negedge clk);
		chk({14'h0000, drive}, 16'h0000);
		repeat (60) @(negedge clk);
		chk_st(pilot_pkg::ST_SELFTEST, 1'b0);
		@(posedge clk);
		selftest_ok <= 1'b1;
		wait_st(pilot_pkg::ST_IDLE, 1'b0);
		hi = 0;
		repeat (PER) begin
			@(negedge clk);
			hi += int'(drive === 2'b10);
		end
		chk(16'(hi), 16'(PER));
	endtask
	// plug in, duty table, charging loads, unplug
	task automatic t_connect;
		set_mode(pilot_pkg::LVL_9V);
		wait_st(pilot_pkg::ST_READY, 1'b1);
		foreach (amps[i])
			t_duty(amps[i]);
		set_mode(pilot_pkg::LVL_6V);
		wait_st(pilot_pkg::ST_CHARGE, 1'b1);
		set_mode(pilot_pkg::LVL_3V);
		wait_st(pilot_pkg::ST_VENT, 1'b1);
		meas();
		chk(16'(per), 16'(PER));
		set_mode(pilot_pkg::LVL_12V);
		wait_st(pilot_pkg::ST_IDLE, 1'b0);
	endtask
	// out-of-range current stays unmodulated, rated value then used
	task automatic t_refuse;
		@(posedge clk);
		derate_amps <= 7'h05;
		set_mode(pilot_pkg::LVL_9V);
		repeat (8 * PER) @(negedge clk);
		chk_st(pilot_pkg::ST_IDLE, 1'b0);
		@(posedge clk);
		derate_en <= 1'b0;
		wait_st(pilot_pkg::ST_READY, 1'b1);
		meas();
		chk(16'(hi), 16'(exp_hi(80)));
		set_mode(pilot_pkg::LVL_12V);
		wait_st(pilot_pkg::ST_IDLE, 1'b0);
	endtask
	// error level, reset in mid-run, then negative-only fault
	task automatic t_fault;
		set_mode(pilot_pkg::LVL_9V);
		wait_st(pilot_pkg::ST_READY, 1'b1);
		set_mode(pilot_pkg::LVL_0V);
		wait_st(pilot_pkg::ST_ERROR, 1'b0);
		chk({14'h0000, drive}, 16'h0001);
		@(posedge clk);
		rst_n <= 1'b0;
		set_mode(pilot_pkg::LVL_9V);
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		wait_st(pilot_pkg::ST_READY, 1'b1);
		set_mode(pilot_pkg::LVL_NEG);
		wait_st(pilot_pkg::ST_FAULT, 1'b0);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_start();
		t_connect();
		t_refuse();
		t_fault();
		final_report();
	end
endmodule
